// file: rtl/flash_self_program_addressing.sv
// pointer decode, signature row, sections and command timing for self-programming
`timescale 1ns/10ps
module flash_self_program_addressing
  import spm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // oscillator tick, one pulse per calibrated oscillator period
  input wire logic osc_tick,
  // fuses and signature contents
  input wire logic boot_size_fuse_high,
  input wire logic boot_size_fuse_low,
  input wire signature_s sig_data,
  // control register write from the core
  input wire logic cmd_write,
  input wire command_s cmd_data,
  // core instructions
  input wire logic store_strobe,
  input wire logic load_strobe,
  input wire logic [15:0] pointer,
  // control register state
  output command_s cmd_state,
  output logic region_busy_flag,
  // flash array side
  output logic erase_start,
  output logic write_start,
  output logic lock_start,
  output logic buffer_load,
  output logic [counter_top_bit:0] flash_word_addr,
  output logic [page_word_top_bit:0] buffer_word,
  output logic halt_cpu,
  output logic flash_busy,
  // signature load answer
  output logic sig_valid,
  output logic [7:0] sig_byte,
  // section map
  output logic [counter_top_bit:0] boot_start,
  output logic in_boot_section,
  output logic in_concurrent_read_region
);
  typedef enum logic [1:0] {idle, armed, timed} state_e;
  state_e state;
  state_e next_state;
  command_s next_cmd_state;
  logic next_region_busy;
  logic [2:0] window;
  logic [2:0] next_window;
  logic next_sig_valid;
  logic [7:0] next_sig_byte;
  logic next_erase;
  logic next_write;
  logic next_lock;
  logic next_load;
  logic next_halt;
  logic [counter_top_bit:0] next_addr;
  logic [page_word_top_bit:0] next_buffer_word;
  logic timer_start;
  logic timer_running;
  logic timer_done;
  pointer_s ptr;

  // pointer bit 0 dropped, bits shift down by one
  assign ptr = pointer_s'(pointer);

  // page pointer bits 15..8 onto counter bits 14..7
  function automatic logic [counter_top_bit:0] page_addr(input pointer_s p);
    page_addr = {p.page_select_field, 7'h00};
  endfunction

  // addresses below the halting start belong to the concurrent region
  function automatic logic in_concurrent(input logic [counter_top_bit:0] a);
    in_concurrent = a < halting_region_start;
  endfunction

  // boot section start from the two fuse bits
  always_comb begin
    unique case ({boot_size_fuse_high, boot_size_fuse_low})
      2'b11: boot_start = boot_start_512;
      2'b10: boot_start = boot_start_1024;
      2'b01: boot_start = boot_start_2048;
      2'b00: boot_start = boot_start_4096;
    endcase
  end

  assign in_boot_section = flash_word_addr >= boot_start &&
                           flash_word_addr <= flash_last_word;
  assign in_concurrent_read_region = in_concurrent(flash_word_addr);
  assign flash_busy = timer_running;

  // signature row lookup; unassigned addresses return 0
  function automatic logic [7:0] sig_lookup(input logic [15:0] a,
                                            input signature_s s);
    logic [7:0] idx;
    sig_lookup = 8'h00;
    idx = 8'h00;
    unique case (a)
      sig_byte1_addr: sig_lookup = s.sig1;
      sig_byte2_addr: sig_lookup = s.sig2;
      sig_byte3_addr: sig_lookup = s.sig3;
      sig_calib_addr: sig_lookup = s.calib;
      default: begin
        // pairs are swapped: 0x0E holds byte 1, 0x0F byte 0
        if (a >= serial_lo_first && a <= serial_lo_last) begin
          idx = 8'(a - serial_lo_first) ^ 8'h01;
          sig_lookup = s.serial[idx*8 +: 8];
        end else if (a >= serial_hi_first && a <= serial_hi_last) begin
          idx = 8'(a - serial_hi_first) + 8'h06;
          sig_lookup = s.serial[idx*8 +: 8];
        end
      end
    endcase
  endfunction

  osc_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(timer_start),
    .osc_tick(osc_tick),
    .running(timer_running),
    .done(timer_done)
  );

  always_comb begin
    next_state = state;
    next_cmd_state = cmd_state;
    next_region_busy = region_busy_flag;
    next_window = window;
    next_sig_valid = 1'b0;
    next_sig_byte = sig_byte;
    next_erase = 1'b0;
    next_write = 1'b0;
    next_lock = 1'b0;
    next_load = 1'b0;
    next_halt = halt_cpu;
    next_addr = flash_word_addr;
    next_buffer_word = buffer_word;
    timer_start = 1'b0;
    unique case (state)
      idle: begin
        // only with enable set; other bit patterns are ignored
        if (cmd_write && cmd_data.command_enable_bit) begin
          next_cmd_state = cmd_data;
          next_window = 3'(store_window);
          next_state = armed;
        end
      end
      armed: begin
        if (cmd_state.signature_read_bit) begin
          if (load_strobe && window > 3'(store_window - load_window)) begin
            next_sig_byte = sig_lookup(pointer, sig_data);
            next_sig_valid = 1'b1;
            next_cmd_state = cmd_reset;
            next_state = idle;
          end else if (window == 3'h1) begin
            next_cmd_state = cmd_reset;
            next_state = idle;
          end else begin
            next_window = window - 3'h1;
          end
        end else if (store_strobe) begin
          if (cmd_state.page_erase_bit || cmd_state.page_write_bit) begin
            next_addr = page_addr(ptr);
            next_erase = cmd_state.page_erase_bit;
            next_write = cmd_state.page_write_bit;
            if (in_concurrent(page_addr(ptr)))
              next_region_busy = 1'b1;
            else
              next_halt = 1'b1;
            timer_start = 1'b1;
            next_state = timed;
          end else if (cmd_state.lock_set_bit) begin
            next_lock = 1'b1;
            timer_start = 1'b1;
            next_state = timed;
          end else if (cmd_state.region_read_reenable_bit) begin
            next_region_busy = 1'b0;
            next_cmd_state = cmd_reset;
            next_state = idle;
          end else begin
            next_buffer_word = ptr.word_in_page_field;
            next_load = 1'b1;
            next_region_busy = 1'b0;
            next_cmd_state = cmd_reset;
            next_state = idle;
          end
        end else if (window == 3'h1) begin
          next_cmd_state = cmd_reset;
          next_state = idle;
        end else begin
          next_window = window - 3'h1;
        end
      end
      timed: begin
        // enable stays set until the oscillator timer finishes
        if (timer_done) begin
          next_cmd_state = cmd_reset;
          next_halt = 1'b0;
          next_state = idle;
        end
      end
      default: next_state = idle;
    endcase
  end

  // an operation already timing survives reset
  always_ff @(posedge mclk) begin
    if (rst && state != timed) begin
      state <= idle;
      cmd_state <= cmd_reset;
      region_busy_flag <= 1'b0;
      window <= '0;
      sig_valid <= 1'b0;
      sig_byte <= 8'h00;
      erase_start <= 1'b0;
      write_start <= 1'b0;
      lock_start <= 1'b0;
      buffer_load <= 1'b0;
      halt_cpu <= 1'b0;
      flash_word_addr <= '0;
      buffer_word <= '0;
    end else begin
      state <= next_state;
      cmd_state <= next_cmd_state;
      region_busy_flag <= next_region_busy;
      window <= next_window;
      sig_valid <= next_sig_valid;
      sig_byte <= next_sig_byte;
      erase_start <= next_erase;
      write_start <= next_write;
      lock_start <= next_lock;
      buffer_load <= next_load;
      halt_cpu <= next_halt;
      flash_word_addr <= next_addr;
      buffer_word <= next_buffer_word;
    end
  end
endmodule

// file: common/spm_pkg.sv
// constants and types for the flash self-programming addressing unit
package spm_pkg;
  localparam int counter_top_bit = 14;
  localparam int page_word_top_bit = 6;
  localparam int pointer_counter_top_bit = counter_top_bit + 1;
  localparam int pointer_page_word_top_bit = page_word_top_bit + 1;
  localparam int pc_width = counter_top_bit + 1;
  localparam int page_words = 128;
  localparam int page_count_concurrent = 224;
  localparam logic [14:0] halting_region_start = 15'h7000;
  localparam logic [14:0] boot_start_512 = 15'h7E00;
  localparam logic [14:0] boot_start_1024 = 15'h7C00;
  localparam logic [14:0] boot_start_2048 = 15'h7800;
  localparam logic [14:0] boot_start_4096 = 15'h7000;
  localparam logic [14:0] flash_last_word = 15'h7FFF;
  localparam logic [15:0] sig_byte1_addr = 16'h0000;
  localparam logic [15:0] sig_calib_addr = 16'h0001;
  localparam logic [15:0] sig_byte2_addr = 16'h0002;
  localparam logic [15:0] sig_byte3_addr = 16'h0004;
  localparam logic [15:0] serial_lo_first = 16'h000E;
  localparam logic [15:0] serial_lo_last = 16'h0013;
  localparam logic [15:0] serial_hi_first = 16'h0015;
  localparam logic [15:0] serial_hi_last = 16'h0017;
  localparam int store_window = 4;
  localparam int load_window = 3;
  localparam int cmd_bit_enable = 0;
  localparam int cmd_bit_erase = 1;
  localparam int cmd_bit_write = 2;
  localparam int cmd_bit_lock = 3;
  localparam int cmd_bit_reenable = 4;
  localparam int cmd_bit_signature_read_bit = 5;
  localparam logic [5:0] cmd_reset = 6'h00;
  // oscillator is nominally 8 MHz once calibrated
  localparam int osc_khz = 8000;
  localparam int prog_min_us = 3700;
  localparam int prog_max_us = 4500;
  localparam int prog_ticks_min = (prog_min_us * osc_khz + 999) / 1000;
  localparam int prog_ticks_max = (prog_max_us * osc_khz) / 1000;
  localparam int mclk_mhz = 125;
  // pointer split into page and word fields
  typedef struct packed {
    logic [7:0] page_select_field;
    logic [6:0] word_in_page_field;
    logic byte_sel;
  } pointer_s;
  typedef struct packed {
    logic command_enable_bit;
    logic page_erase_bit;
    logic page_write_bit;
    logic lock_set_bit;
    logic region_read_reenable_bit;
    logic signature_read_bit;
  } command_s;
  typedef struct packed {
    logic [7:0] sig1;
    logic [7:0] sig2;
    logic [7:0] sig3;
    logic [7:0] calib;
    logic [71:0] serial;
  } signature_s;
endpackage

// file: rtl/osc_timer.sv
// programming-time counter clocked from oscillator ticks
`timescale 1ns/10ps
module osc_timer
  import spm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic osc_tick,
  // status
  output logic running,
  output logic done
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_running;
  logic next_done;

  // reset deliberately does not stop a running operation
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (start && !running) begin
      next_count = '0;
      next_running = 1'b1;
    end else if (running && osc_tick) begin
      if (count == 16'(prog_ticks_min - 1)) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst && !running) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule

// file: testbench/flash_addr_asserts.sv
// assertion checker for the self-programming addressing unit
`timescale 1ns/10ps
module flash_addr_checker
  import spm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // inputs
  input wire logic boot_size_fuse_high,
  input wire logic boot_size_fuse_low,
  input wire signature_s sig_data,
  input wire logic store_strobe,
  input wire logic load_strobe,
  input wire logic [15:0] pointer,
  // outputs
  input wire command_s cmd_state,
  input wire logic region_busy_flag,
  input wire logic erase_start,
  input wire logic write_start,
  input wire logic buffer_load,
  input wire logic [14:0] flash_word_addr,
  input wire logic [6:0] buffer_word,
  input wire logic halt_cpu,
  input wire logic flash_busy,
  input wire logic sig_valid,
  input wire logic [7:0] sig_byte,
  input wire logic [14:0] boot_start,
  input wire logic in_concurrent_read_region
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  boot_start_map_a: assert property (
    boot_start == (boot_size_fuse_high ?
    (boot_size_fuse_low ? 15'h7E00 : 15'h7C00) :
    (boot_size_fuse_low ? 15'h7800 : 15'h7000))) else $error("boot start");
  region_split_a: assert property (
    in_concurrent_read_region == (flash_word_addr <= 15'h6FFF))
    else $error("region decode");
  erase_page_a: assert property (
    erase_start |-> ##[0:1] flash_word_addr == {pointer[15:8], 7'h00})
    else $error("erase page address");
  buffer_word_a: assert property (
    buffer_load |-> ##[0:1] buffer_word == pointer[7:1])
    else $error("buffer word");
  region_busy_set_a: assert property (
    erase_start && flash_word_addr < 15'h7000 |-> ##[0:1] region_busy_flag)
    else $error("region busy not set");
  halt_region_a: assert property (
    (erase_start || write_start) && flash_word_addr >= halting_region_start
    |-> ##[0:1] halt_cpu) else $error("cpu not halted");
  busy_holds_en_a: assert property (
    flash_busy |-> cmd_state.command_enable_bit) else $error("enable dropped");
  window_expiry_a: assert property (
    $rose(cmd_state.command_enable_bit) ##0 (!store_strobe && !load_strobe)[*4]
    |=> !cmd_state.command_enable_bit) else $error("window kept open");
  sig_calib_a: assert property (
    sig_valid && pointer == 16'h0001 |-> sig_byte == sig_data.calib)
    else $error("calibration byte");
  sig_cause_a: assert property (
    sig_valid |-> $past(load_strobe)) else $error("signature without load");
endmodule
bind flash_self_program_addressing flash_addr_checker flash_addr_checker_inst (.*);

// file: testbench/cpu_core_model.sv
// core-side model issuing control writes, stores and loads
`timescale 1ns/10ps
module cpu_core_model
  import spm_pkg::*;
(
  // clock
  input wire logic mclk,
  // core requests
  output logic cmd_write,
  output command_s cmd_data,
  output logic store_strobe,
  output logic load_strobe,
  output logic [15:0] pointer
);
  initial begin
    cmd_write = 1'b0;
    cmd_data = '0;
    store_strobe = 1'b0;
    load_strobe = 1'b0;
    pointer = 16'h0000;
  end
  // callers zero pointer bits 7..1 for page write; reserved rows 0x0003 and 0x0014 are read and checked as 0
  task automatic op(input command_s c, input logic [15:0] p, input bit ld,
    input int gap);
    @(negedge mclk);
    cmd_write = 1'b1;
    cmd_data = c;
    pointer = p;
    @(negedge mclk);
    cmd_write = 1'b0;
    // data is only meaningful with the write strobe, so scramble it
    cmd_data = ~c;
    repeat (gap - 1) @(negedge mclk);
    store_strobe = !ld;
    load_strobe = ld;
    @(negedge mclk);
    store_strobe = 1'b0;
    load_strobe = 1'b0;
  endtask
endmodule

// file: testbench/tb_top.sv
// testbench for the self-programming addressing unit
`timescale 1ns/10ps
module tb_top;
  import spm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, osc_tick = 1'b1, fh = 1'b1, fl = 1'b1;
  signature_s sig_data;
  logic cmd_write, store_strobe, load_strobe, region_busy_flag;
  logic erase_start, write_start, buffer_load, halt_cpu, flash_busy;
  logic sig_valid, lock_start, in_boot_section, in_concurrent_read_region;
  command_s cmd_data, cmd_state;
  logic [15:0] pointer;
  logic [14:0] flash_word_addr, boot_start;
  logic [6:0] buffer_word;
  logic [7:0] sig_byte;
  int fails = 0, checked = 0, cycles = 0;
  logic [15:0] sa [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h000E,
    16'h000F, 16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0015, 16'h0016,
    16'h0017, 16'h0003, 16'h0014};
  logic [7:0] se [15] = '{8'h11, 8'h5A, 8'h22, 8'h33, 8'hA1, 8'hA0, 8'hA3,
    8'hA2, 8'hA5, 8'hA4, 8'hA6, 8'hA7, 8'hA8, 8'h00, 8'h00};
  logic [14:0] bs [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 70000) begin
      fails++;
      test_done();
    end
  end
  cpu_core_model cpu_core_model_inst (.mclk(mclk), .cmd_write(cmd_write),
    .cmd_data(cmd_data), .store_strobe(store_strobe),
    .load_strobe(load_strobe), .pointer(pointer));
  flash_self_program_addressing flash_self_program_addressing_inst (
    .mclk(mclk), .rst(rst), .osc_tick(osc_tick), .boot_size_fuse_high(fh),
    .boot_size_fuse_low(fl), .sig_data(sig_data), .cmd_write(cmd_write),
    .cmd_data(cmd_data), .store_strobe(store_strobe),
    .load_strobe(load_strobe), .pointer(pointer), .cmd_state(cmd_state),
    .region_busy_flag(region_busy_flag), .erase_start(erase_start),
    .write_start(write_start), .lock_start(lock_start),
    .buffer_load(buffer_load),
    .flash_word_addr(flash_word_addr), .buffer_word(buffer_word),
    .halt_cpu(halt_cpu), .flash_busy(flash_busy), .sig_valid(sig_valid),
    .sig_byte(sig_byte), .boot_start(boot_start),
    .in_boot_section(in_boot_section),
    .in_concurrent_read_region(in_concurrent_read_region));
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // count busy cycles; hit pulses reset mid-operation
  // 64 withheld ticks must stretch the operation by 64 cycles
  task automatic run(input bit hit);
    int n, k;
    bit ok;
    n = 0;
    for (k = 0; k < 5 && flash_busy !== 1'b1; k++) @(negedge mclk);
    while (flash_busy === 1'b1 && n < 40000) begin
      rst = hit && n >= 100 && n < 102;
      osc_tick = !(n >= 200 && n < 264);
      n++;
      @(negedge mclk);
    end
    ok = n - 64 >= prog_ticks_min && n - 64 <= prog_ticks_max;
    chk("busy_ticks", 1, ok);
    for (k = 0; k < 3 && cmd_state.command_enable_bit !== 1'b0; k++)
      @(negedge mclk);
    chk("cmd_state", cmd_reset, cmd_state);
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // command codes: enable 6'h20, signature_read_bit 6'h21, erase 6'h30, write 6'h28
  initial begin
    int i, k;
    sig_data = {8'h11, 8'h22, 8'h33, 8'h5A, 72'h0};
    for (i = 0; i < 9; i++) sig_data.serial[8*i+:8] = 8'(8'hA0 + i);
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    for (i = 0; i < 4; i++) begin
      {fh, fl} = 2'(i);
      @(negedge mclk);
      chk("boot_start", bs[i], boot_start);
    end
    for (i = 0; i < 15; i++) begin
      cpu_core_model_inst.op(6'h21, sa[i], 1'b1, 1 + i % 3);
      for (k = 0; k < 3 && sig_valid !== 1'b1; k++) @(negedge mclk);
      chk("sig_byte", se[i], sig_byte);
    end
    cpu_core_model_inst.op(6'h20, 16'h0010, 1'b0, 6);
    chk("late_store", 0, buffer_word);
    cpu_core_model_inst.op(6'h30, 16'hDF00, 1'b0, 2);
    for (k = 0; k < 3 && erase_start !== 1'b1; k++) @(negedge mclk);
    chk("erase_addr", 15'h6F80, flash_word_addr);
    chk("in_boot", 0, in_boot_section);
    chk("in_region", 1, in_concurrent_read_region);
    run(1'b0);
    chk("region_busy", 1, region_busy_flag);
    cpu_core_model_inst.op(6'h20, 16'h00FE, 1'b0, 4);
    for (k = 0; k < 3 && buffer_load !== 1'b1; k++) @(negedge mclk);
    chk("buffer_word", 7'h7F, buffer_word);
    chk("region_free", 0, region_busy_flag);
    cpu_core_model_inst.op(6'h28, 16'hFE00, 1'b0, 3);
    for (k = 0; k < 3 && write_start !== 1'b1; k++) @(negedge mclk);
    chk("write_addr", 15'h7F00, flash_word_addr);
    chk("halt_cpu", 1, halt_cpu);
    chk("in_boot", 1, in_boot_section);
    run(1'b1);
    chk("halt_free", 0, halt_cpu);
    // commands issued while an erase is timing must have no effect
    cpu_core_model_inst.op(6'h30, 16'h0000, 1'b0, 1);
    for (k = 0; k < 3 && erase_start !== 1'b1; k++) @(negedge mclk);
    chk("erase_addr", 15'h0000, flash_word_addr);
    chk("region_busy", 1, region_busy_flag);
    cpu_core_model_inst.op(6'h22, 16'h0000, 1'b0, 2);
    chk("reenable_void", 1, region_busy_flag);
    cpu_core_model_inst.op(6'h24, 16'h0001, 1'b0, 2);
    chk("lock_void", 0, lock_start);
    chk("cmd_held", 6'h30, cmd_state);
    test_done();
  end
endmodule
